// [shared/flash_wp_pkg.sv]
// constants and types for the flash write-protect and power-mode controller
package flash_wp_pkg;
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS3_WRITE = 8'hc0;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_FOUR_KB_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_DEEP_POWER_DOWN_ENTRY = 8'hb9;
  localparam logic [7:0] OP_WAKE_AND_ID_READ = 8'hab;
  // status byte positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_LVL = 2;
  localparam int ST_TB = 5;
  localparam int ST_GRAN = 6;
  localparam int ST_LOCK = 7;
  localparam int ST3_CMP = 0;
  // frame length checks, in bytes
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  localparam logic [2:0] LEN_ERASE = 3'h4;
  localparam logic [2:0] LEN_PROGRAM = 3'h5;
  // array geometry
  localparam logic [23:0] ARRAY_TOP = 24'h1fffff;
  localparam logic [23:0] SIZE_4K = 24'h001000;
  localparam logic [23:0] SIZE_64K = 24'h010000;
  localparam logic [23:0] MASK_PAGE = 24'h0000ff;
  localparam logic [23:0] MASK_4K = 24'h000fff;
  localparam logic [23:0] MASK_32K = 24'h007fff;
  localparam logic [23:0] MASK_64K = 24'h00ffff;
  // timing defaults, in clock cycles at 125 MHz
  localparam int CYCLE_LEN_DEFAULT = 32;
  localparam int PUW_LEN_DEFAULT = 1000;

  typedef struct packed {
    logic cmp;
    logic gran;
    logic tb;
    logic [2:0] lvl;
  } prot_t;

  localparam prot_t PROT_RESET = 6'h00;

  typedef struct packed {
    logic any;
    logic [23:0] lo;
    logic [23:0] hi;
  } range_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ACTIVE = 2'b01,
    PWR_DEEP = 2'b10
  } pwr_t;
endpackage

// [rtl/flash_write_protect_power_ctl.sv]
// write-protect, busy flag and power-mode control of a serial flash
`timescale 1ns/1ns
`default_nettype none
module flash_write_protect_power_ctl
  import flash_wp_pkg::*;
#(
  parameter int CYCLE_LEN = CYCLE_LEN_DEFAULT,
  parameter int PUW_LEN = PUW_LEN_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  output logic [7:0] o_status,
  output prot_t o_protect,
  output pwr_t o_power_mode,
  output logic o_hw_locked,
  output logic o_inhibit,
  output logic o_cmd_done,
  output logic o_cmd_ignored
);

  localparam int CW = $clog2(CYCLE_LEN + 1);
  localparam int PW = $clog2(PUW_LEN + 1);
  localparam logic [CW-1:0] CYC_LOAD = CW'(CYCLE_LEN - 1);
  localparam logic [PW-1:0] PUW_LOAD = PW'(PUW_LEN);

  function automatic range_t prot_range(prot_t p);
    range_t r;
    logic [23:0] sz;
    logic all, none;
    r = '0;
    sz = '0;
    all = 1'b0;
    none = 1'b0;
    if (p.lvl == 3'h0) begin
      none = 1'b1;
    end else if (p.lvl[2:1] == 2'h3) begin
      all = 1'b1;
    end else if (!p.gran) begin
      sz = SIZE_64K << (p.lvl - 3'h1);
    end else begin
      sz = SIZE_4K << (p.lvl[2] ? 3'h3 : p.lvl - 3'h1);
    end
    if (p.cmp) begin
      {all, none} = {none, all};
    end
    if (all) begin
      r = {1'b1, 24'h000000, ARRAY_TOP};
    end else if (!none) begin
      r.any = 1'b1;
      // complement of a top region is the bottom remainder, and vice versa
      if (p.tb == p.cmp) begin
        r.hi = ARRAY_TOP;
        r.lo = p.cmp ? sz : ARRAY_TOP - sz + 24'h000001;
      end else begin
        r.lo = 24'h000000;
        r.hi = p.cmp ? ARRAY_TOP - sz : sz - 24'h000001;
      end
    end
    return r;
  endfunction

  function automatic logic [23:0] op_mask(logic [7:0] op);
    logic [23:0] m;
    m = MASK_PAGE;
    if (op == OP_FOUR_KB_ERASE) begin
      m = MASK_4K;
    end else if (op == OP_HALF_BLOCK_ERASE) begin
      m = MASK_32K;
    end else if (op == OP_BLOCK_ERASE) begin
      m = MASK_64K;
    end else if (op == OP_CHIP_ERASE) begin
      m = ARRAY_TOP;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // frame capture
  logic sck_q_r, cs_q_r, sck_rise, cs_rise;
  logic [6:0] shift_r;
  logic [2:0] bit_cnt_r, byte_cnt_r;
  logic [7:0] opcode_r, data_r, byte_in;
  logic [23:0] addr_r;

  assign sck_rise = i_sck & ~sck_q_r & ~i_cs_n;
  assign cs_rise = i_cs_n & ~cs_q_r;
  assign byte_in = {shift_r, i_mosi};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else begin
      sck_q_r <= i_sck;
      cs_q_r <= i_cs_n;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_r <= '0;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      opcode_r <= '0;
      data_r <= '0;
      addr_r <= '0;
    end else if (i_cs_n) begin
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
    end else if (sck_rise) begin
      shift_r <= byte_in[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        // saturates: seven means seven or more bytes
        if (byte_cnt_r != 3'h7) begin
          byte_cnt_r <= byte_cnt_r + 3'h1;
        end
        if (byte_cnt_r == 3'h0) begin
          opcode_r <= byte_in;
        end
        if (byte_cnt_r == 3'h1) begin
          data_r <= byte_in;
        end
        if (byte_cnt_r != 3'h0 && byte_cnt_r < LEN_ERASE) begin
          addr_r <= {addr_r[15:0], byte_in};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decision at chip-select release
  logic busy_r, latch_r, deep_r, inhibit_r, lock_r, done_r, ignored_r;
  prot_t prot_r;
  logic [CW-1:0] cyc_cnt_r;
  logic [PW-1:0] puw_cnt_r;
  pwr_t power_mode_r;

  logic aligned, hw_locked, is_array_op, is_status_op, hit, live;
  logic arm_ok, disarm_ok, deep_ok, wake_ok, start_ok, finish;
  range_t prange;
  logic [23:0] t_lo, t_hi;

  assign aligned = (bit_cnt_r == 3'h0) && (byte_cnt_r != 3'h0);
  assign hw_locked = lock_r & ~i_wp_n;
  assign prange = prot_range(prot_r);
  assign t_lo = addr_r & ~op_mask(opcode_r);
  assign t_hi = addr_r | op_mask(opcode_r);
  assign hit = prange.any && !(t_hi < prange.lo || t_lo > prange.hi);
  assign is_status_op = (opcode_r == OP_STATUS_WRITE) || (opcode_r == OP_STATUS3_WRITE);

  always_comb begin
    is_array_op = 1'b0;
    if (opcode_r == OP_PAGE_PROGRAM || opcode_r == OP_QUAD_PAGE_PROGRAM) begin
      is_array_op = byte_cnt_r >= LEN_PROGRAM;
    end else if (opcode_r == OP_FOUR_KB_ERASE || opcode_r == OP_HALF_BLOCK_ERASE ||
                 opcode_r == OP_BLOCK_ERASE) begin
      is_array_op = byte_cnt_r == LEN_ERASE;
    end else if (opcode_r == OP_CHIP_ERASE) begin
      is_array_op = byte_cnt_r == LEN_ONE;
    end
  end

  // deep-down and a running cycle gate everything else off
  assign live = cs_rise & ~deep_r & ~busy_r;
  assign wake_ok = cs_rise & deep_r & (opcode_r == OP_WAKE_AND_ID_READ) &
                   (byte_cnt_r != 3'h0);
  assign arm_ok = live & aligned & (byte_cnt_r == LEN_ONE) &
                  (opcode_r == OP_WRITE_ARM) & ~inhibit_r;
  assign disarm_ok = live & aligned & (byte_cnt_r == LEN_ONE) &
                     (opcode_r == OP_WRITE_DISARM);
  assign deep_ok = live & aligned & (byte_cnt_r == LEN_ONE) &
                   (opcode_r == OP_DEEP_POWER_DOWN_ENTRY);
  assign start_ok = live & aligned & latch_r & ~inhibit_r &
                    ((is_array_op & ~hit) |
                     (is_status_op & (byte_cnt_r >= LEN_STATUS) & ~hw_locked));
  assign finish = busy_r && (cyc_cnt_r == '0);

  ////////////////////////////////////////////////////////////////////////////
  // power-up inhibit timer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      inhibit_r <= 1'b1;
      puw_cnt_r <= PUW_LOAD;
    end else if (puw_cnt_r != '0) begin
      puw_cnt_r <= puw_cnt_r - PW'(1);
    end else begin
      inhibit_r <= 1'b0;
    end
  end

  // internal cycle and write latch
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_r <= 1'b0;
      cyc_cnt_r <= '0;
    end else if (start_ok) begin
      busy_r <= 1'b1;
      cyc_cnt_r <= CYC_LOAD;
    end else if (finish) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cyc_cnt_r <= cyc_cnt_r - CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_r <= 1'b0;
    end else if (finish || disarm_ok) begin
      latch_r <= 1'b0;
    end else if (arm_ok) begin
      latch_r <= 1'b1;
    end
  end

  // protect and lock bits take effect at accept; the cycle only keeps busy up
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prot_r <= PROT_RESET;
      lock_r <= 1'b0;
    end else if (start_ok && opcode_r == OP_STATUS_WRITE) begin
      prot_r.gran <= data_r[ST_GRAN];
      prot_r.tb <= data_r[ST_TB];
      prot_r.lvl <= data_r[ST_LVL +: 3];
      lock_r <= data_r[ST_LOCK];
    end else if (start_ok && opcode_r == OP_STATUS3_WRITE) begin
      prot_r.cmp <= data_r[ST3_CMP];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      deep_r <= 1'b0;
    end else if (deep_ok) begin
      deep_r <= 1'b1;
    end else if (wake_ok) begin
      deep_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      power_mode_r <= PWR_STANDBY;
    end else if (deep_r) begin
      power_mode_r <= PWR_DEEP;
    end else if (!i_cs_n || busy_r) begin
      power_mode_r <= PWR_ACTIVE;
    end else begin
      power_mode_r <= PWR_STANDBY;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_r <= 1'b0;
      ignored_r <= 1'b0;
    end else begin
      done_r <= finish;
      ignored_r <= cs_rise & ~(start_ok | arm_ok | disarm_ok | deep_ok | wake_ok);
    end
  end

  assign o_status = {lock_r, prot_r.gran, prot_r.tb, prot_r.lvl, latch_r, busy_r};
  assign o_protect = prot_r;
  assign o_power_mode = power_mode_r;
  assign o_hw_locked = hw_locked;
  assign o_inhibit = inhibit_r;
  assign o_cmd_done = done_r;
  assign o_cmd_ignored = ignored_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  busy_min_a: assert property ($rose(busy_r) |-> busy_r[*8])
    else $error("busy dropped early");
  busy_end_a: assert property ($rose(busy_r) |-> ##[1:1000] !busy_r)
    else $error("busy never cleared");
  latch_with_busy_a: assert property ($fell(busy_r) |-> !latch_r && o_cmd_done == 1'b1)
    else $error("latch not cleared with busy");
  mode_active_a: assert property (!i_cs_n && !deep_r |=> power_mode_r == PWR_ACTIVE)
    else $error("not active while selected");
  mode_standby_a: assert property (i_cs_n && !busy_r && !deep_r |=> power_mode_r == PWR_STANDBY)
    else $error("not standby when idle");
  deep_entry_a: assert property (deep_ok |=> deep_r ##1 power_mode_r == PWR_DEEP)
    else $error("deep entry missed");
  deep_ignore_a: assert property (deep_r && cs_rise && opcode_r != OP_WAKE_AND_ID_READ
                                  |=> deep_r && $stable(latch_r) && !busy_r)
    else $error("command acted in deep-down");
  misalign_a: assert property (cs_rise && !aligned |=> !$rose(busy_r) && !$rose(latch_r))
    else $error("misaligned frame accepted");
  need_latch_a: assert property ($rose(busy_r) |-> $past(latch_r))
    else $error("cycle without write latch");
  inhibit_block_a: assert property (inhibit_r |=> !$rose(busy_r) && !$rose(latch_r))
    else $error("modify during power-up");
  protect_hit_a: assert property (cs_rise && is_array_op && hit |=> !$rose(busy_r))
    else $error("protected region modified");
  hw_lock_a: assert property (hw_locked && cs_rise |=> $stable(prot_r) && $stable(lock_r))
    else $error("locked bits changed");
  busy_ignore_a: assert property (busy_r && cyc_cnt_r != '0 |=> $stable(prot_r) && busy_r)
    else $error("cycle disturbed");
  decode_top_a: assert property (prot_r == 6'h01 |-> prange.lo == 24'h1f0000)
    else $error("64KB top decode wrong");
  decode_cmp_a: assert property (prot_r == 6'h3b |-> prange.lo == 24'h004000)
    else $error("complement decode wrong");

  cover_program_c: cover property ($rose(busy_r) ##[1:1000] $fell(busy_r));
  cover_deep_c: cover property (deep_ok ##[1:1000] wake_ok);
  cover_protect_c: cover property (cs_rise && is_array_op && hit && latch_r);
  cover_locked_c: cover property (cs_rise && is_status_op && hw_locked && latch_r);

endmodule
`default_nettype wire

// [tb/spi_host_model.sv]
// spi host model that frames commands toward the flash controller
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic i_clk,
  output var logic o_cs_n,
  output var logic o_sck,
  output var logic o_mosi
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode 0, msb first; whole bytes are the host's duty, short counts on request
  task automatic frame(input logic [39:0] d, input int n, input int slow);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sck <= 1'b0;
      o_mosi <= d[39 - i];
      repeat (1 + slow) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (1 + slow) @(posedge i_clk);
    end
    o_sck <= 1'b0;
    repeat (1 + slow) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // released line must not keep showing the last bit
    o_mosi <= ~o_mosi;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// [tb/flash_write_protect_power_ctl_test.sv]
// self-checking bench for the flash write-protect and power-mode controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module flash_write_protect_power_ctl_test import flash_wp_pkg::*;;
  logic clk, resetn, wp_n, hw_lk, inhibit, done, ign;
  wire logic cs_n, sck, mosi;
  logic [7:0] status;
  prot_t protect, p;
  pwr_t mode;
  logic [23:0] a;
  logic [1:0] e;
  logic [1:0] exp_q[$];
  logic [31:0] seed = 32'h20e4;
  int num_errors = 0;
  int checked = 0;
  int slow = 0;
  logic [7:0] ops [6] = '{OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_FOUR_KB_ERASE,
                          OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
  int lens [6] = '{40, 40, 32, 32, 32, 8};

  initial clk = 1'b0;
  always #4 clk = ~clk;

  flash_write_protect_power_ctl #(.CYCLE_LEN(64), .PUW_LEN(40)) u_flash_write_protect_power_ctl (
    .i_clk(clk), .i_resetn(resetn), .i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi),
    .i_wp_n(wp_n), .o_status(status), .o_protect(protect), .o_power_mode(mode),
    .o_hw_locked(hw_lk), .o_inhibit(inhibit), .o_cmd_done(done), .o_cmd_ignored(ign));

  spi_host_model u_spi_host_model (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // protected test of one address, worked out from the level table
  function automatic logic hit(input prot_t q, input logic [23:0] ad);
    logic [23:0] sz;
    logic in;
    sz = q.gran ? (q.lvl[2] ? 24'h008000 : 24'h001000 << (q.lvl - 3'h1))
                : 24'h010000 << (q.lvl - 3'h1);
    in = q.tb ? (ad < sz) : (ad >= 24'h200000 - sz);
    if (q.lvl == 3'h0) in = 1'b0;
    else if (q.lvl[2:1] == 2'b11) in = 1'b1;
    return in ^ q.cmp;
  endfunction

  task automatic end_of_test;
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic settle;
    @(negedge clk);
  endtask

  task automatic cmd(input logic [39:0] d, input int n, input logic [1:0] ev);
    if (ev != 2'b00) exp_q.push_back(ev);
    u_spi_host_model.frame(d, n, slow);
    settle();
  endtask

  task automatic arm;
    cmd({OP_WRITE_ARM, 32'h0}, 8, 2'b00);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (status[0] !== 1'b0 && k < 500) begin
      settle();
      k++;
    end
    `CHK(k < 500, 1'b1)
    repeat (2) settle();
  endtask

  task automatic write_prot(input prot_t q, input logic [1:0] ev);
    arm();
    cmd({OP_STATUS_WRITE, 1'b0, q.gran, q.tb, q.lvl, 2'b00, 24'h0}, 16, ev);
    wait_idle();
    arm();
    cmd({OP_STATUS3_WRITE, 7'h00, q.cmp, 24'h0}, 16, ev);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // pulses are matched in order against the notes left by the driver
  always @(negedge clk) begin
    if (done === 1'b1 || ign === 1'b1) begin
      e = (exp_q.size() == 0) ? 2'b00 : exp_q.pop_front();
      `CHK({done, ign}, e)
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    settle();
    `CHK(status, 8'h00)
    `CHK(mode, PWR_STANDBY)
    @(posedge clk);
    resetn <= 1'b1;
    cmd({OP_WRITE_ARM, 32'h0}, 8, 2'b01);
    `CHK({inhibit, status[1]}, 2'b10)
    for (int k = 0; k < 80 && inhibit !== 1'b0; k++) settle();
    `CHK(inhibit, 1'b0)
    arm();
    `CHK(status[1], 1'b1)
    cmd({OP_WRITE_DISARM, 32'h0}, 8, 2'b00);
    `CHK(status[1], 1'b0)
    cmd({OP_PAGE_PROGRAM, 32'h0}, 40, 2'b01);
    arm();
    cmd({OP_PAGE_PROGRAM, 32'h0}, 39, 2'b01);
    `CHK(status[1], 1'b1)
    cmd(40'h0, 0, 2'b01);
    for (int i = 0; i < 6; i++) begin
      arm();
      cmd({ops[i], 24'h000100, 8'h5a}, lens[i], 2'b10);
      `CHK(status[1:0], 2'b11)
      `CHK(mode, PWR_ACTIVE)
      if (i == 0) begin
        exp_q.push_front(2'b01);
        arm();
        `CHK(status[0], 1'b1)
      end
      wait_idle();
      `CHK(status[1:0], 2'b00)
      `CHK(mode, PWR_STANDBY)
    end
    for (int j = 0; j < 16; j++) begin
      seed = lfsr(seed);
      p = prot_t'(seed[5:0]);
      a = {3'h0, seed[26:6]};
      if (seed[27]) a[20:16] = {5{seed[28]}};
      slow = int'(seed[29]);
      write_prot(p, 2'b10);
      `CHK(protect, p)
      arm();
      cmd({OP_PAGE_PROGRAM, a, 8'h00}, 40, hit(p, a) ? 2'b01 : 2'b10);
      wait_idle();
    end
    slow = 0;
    write_prot(prot_t'(6'h01), 2'b10);
    arm();
    cmd({OP_PAGE_PROGRAM, 24'h1f0000, 8'h00}, 40, 2'b01);
    cmd({OP_PAGE_PROGRAM, 24'h1eff00, 8'h00}, 40, 2'b10);
    wait_idle();
    `CHK(protect, prot_t'(6'h01))
    write_prot(prot_t'(6'h3b), 2'b10);
    arm();
    cmd({OP_PAGE_PROGRAM, 24'h004000, 8'h00}, 40, 2'b01);
    cmd({OP_PAGE_PROGRAM, 24'h003f00, 8'h00}, 40, 2'b10);
    wait_idle();
    `CHK(protect, prot_t'(6'h3b))
    write_prot(PROT_RESET, 2'b10);
    arm();
    cmd({OP_STATUS_WRITE, 8'h80, 24'h0}, 16, 2'b10);
    wait_idle();
    @(posedge clk);
    wp_n <= 1'b0;
    settle();
    `CHK(hw_lk, 1'b1)
    write_prot(prot_t'(6'h25), 2'b01);
    `CHK({status[7], protect}, 7'h40)
    @(posedge clk);
    wp_n <= 1'b1;
    settle();
    `CHK(hw_lk, 1'b0)
    arm();
    cmd({OP_STATUS_WRITE, 8'h00, 24'h0}, 16, 2'b10);
    wait_idle();
    cmd({OP_DEEP_POWER_DOWN_ENTRY, 32'h0}, 8, 2'b00);
    `CHK(mode, PWR_DEEP)
    cmd({OP_WRITE_ARM, 32'h0}, 8, 2'b01);
    `CHK({mode, status[1]}, {PWR_DEEP, 1'b0})
    cmd({OP_WAKE_AND_ID_READ, 32'h0}, 12, 2'b00);
    `CHK(mode, PWR_STANDBY)
    arm();
    @(posedge clk);
    resetn <= 1'b0;
    settle();
    `CHK({status, inhibit}, 9'h001)
    @(posedge clk);
    resetn <= 1'b1;
    repeat (5) settle();
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
`default_nettype wire
